//--- core/tcm_defs.vh
// Function
// - address msb high reaches data and connection memories
// - address msb low reaches internal registers only
// - control register bits 1-0 pick data memory, low or high connection word
// - memory address: upper field picks stream 0-31, low eight bits channel 0-255
// - 2.048 Mbps uses channels 0-31, 4.096 Mbps uses 0-63
// - 8.192 Mbps uses channels 0-127, 16.384 Mbps uses 0-255
// - connection mode bit zero selects normal switching from programmed source
// - bits 13-9 give source stream, bits 8-1 source channel
// - bit 14 picks constant-delay (low) or variable-delay (high) memory
// - connection mode bit one selects tristate, message or BER per channel
// - per-channel ctrl 00 tristate, 01 message, 10 BER, 11 reserved
`ifndef TCM_DEFS_VH
`define TCM_DEFS_VH
`define TCM_ADDR_W 14
`define TCM_ADDR_MSB 13
`define TCM_STREAM_HI 12
`define TCM_STREAM_LO 8
`define TCM_CHAN_HI 7
`define TCM_CHAN_LO 0
`define TCM_SEL_DM 2'h0
`define TCM_SEL_CML 2'h1
`define TCM_SEL_CMH 2'h2
`define TCM_CTRL_OFS 13'h0000
`define TCM_CTRL_RESET 16'h0000
`define TCM_CTRL_VARIABLE_DELAY_ENABLE_BIT 2
`define TCM_CML_LAW_CONVERT_ENABLE 15
`define TCM_CML_VC 14
`define TCM_CML_SSA_HI 13
`define TCM_CML_SSA_LO 9
`define TCM_CML_SCA_HI 8
`define TCM_CML_SCA_LO 1
`define TCM_CML_CMM 0
`define TCM_CML_PCC_HI 2
`define TCM_CML_PCC_LO 1
`define TCM_CML_MSG_HI 10
`define TCM_CML_MSG_LO 3
`define TCM_PCC_TRI 2'h0
`define TCM_PCC_MSG 2'h1
`define TCM_PCC_BER 2'h2
`define TCM_PCC_RSV 2'h3
`define TCM_RATE_2M 2'h0
`define TCM_RATE_4M 2'h1
`define TCM_RATE_8M 2'h2
`define TCM_RATE_16M 2'h3
`endif

//--- core/tcm_chan_limit.v
`timescale 1ns/1ps
`include "tcm_defs.vh"
module tcm_chan_limit (
  rate,
  chan,
  in_range
);
  input wire [1:0] rate;
  input wire [7:0] chan;
  output reg in_range;
  always @* begin
    case (rate)
      `TCM_RATE_2M: in_range = (chan[7:5] == 3'h0);
      `TCM_RATE_4M: in_range = (chan[7:6] == 2'h0);
      `TCM_RATE_8M: in_range = (chan[7] == 1'b0);
      `TCM_RATE_16M: in_range = 1'b1;
      default: in_range = 1'b0;
    endcase
  end
endmodule // tcm_chan_limit

//--- core/tcm_switch_map.v
`timescale 1ns/1ps
`include "tcm_defs.vh"
module tcm_switch_map #(
  parameter N_STREAM = 32,
  parameter N_CHAN = 256
) (
  input wire clk_sys,
  input wire rst_b,
  input wire cs_b,
  input wire wr,
  input wire rd,
  input wire [13:0] addr,
  input wire [15:0] wdata,
  input wire [63:0] stream_rate,
  input wire [4:0] out_stream,
  input wire [7:0] out_chan,
  output reg [15:0] rdata,
  output reg rvalid,
  output reg [15:0] ctrl_reg,
  output reg [4:0] src_stream,
  output reg [7:0] src_chan,
  output reg src_variable,
  output reg sw_normal,
  output reg law_convert_enable,
  output reg [15:0] law_word,
  output reg [1:0] per_channel_ctrl,
  output reg [7:0] msg_data,
  output reg out_tristate,
  output reg out_message,
  output reg out_ber,
  output reg addr_drop
);
  localparam DEPTH = N_STREAM * N_CHAN;
  reg [15:0] data_mem [0:DEPTH-1];
  reg [15:0] cml_mem [0:DEPTH-1];
  reg [15:0] cmh_mem [0:DEPTH-1];
  wire mem_space;
  wire [4:0] a_stream;
  wire [7:0] a_chan;
  wire [12:0] a_idx;
  wire [12:0] o_idx;
  wire [1:0] a_rate;
  wire a_ok;
  wire [1:0] mem_sel;
  wire [15:0] conn_low;
  wire [15:0] conn_high;
  wire acc;
  reg [15:0] next_rdata;
  assign acc = !cs_b && (wr || rd);
  assign mem_space = addr[`TCM_ADDR_MSB];
  assign a_stream = addr[`TCM_STREAM_HI:`TCM_STREAM_LO];
  assign a_chan = addr[`TCM_CHAN_HI:`TCM_CHAN_LO];
  assign a_idx = {a_stream, a_chan};
  assign o_idx = {out_stream, out_chan};
  assign a_rate = stream_rate[{a_stream, 1'b0} +: 2];
  assign mem_sel = ctrl_reg[1:0];
  // channels beyond the stream's rate are dropped, not aliased
  tcm_chan_limit u_limit (
    .rate(a_rate),
    .chan(a_chan),
    .in_range(a_ok)
  );
  always @(posedge clk_sys) begin
    if (acc && wr && mem_space && a_ok) begin
      case (mem_sel)
        `TCM_SEL_DM: data_mem[a_idx] <= wdata;
        `TCM_SEL_CML: cml_mem[a_idx] <= wdata;
        `TCM_SEL_CMH: cmh_mem[a_idx] <= wdata;
        default: ;
      endcase
    end
  end
  always @* begin
    next_rdata = 16'h0000;
    if (mem_space) begin
      if (a_ok) begin
        case (mem_sel)
          `TCM_SEL_DM: next_rdata = data_mem[a_idx];
          `TCM_SEL_CML: next_rdata = cml_mem[a_idx];
          `TCM_SEL_CMH: next_rdata = cmh_mem[a_idx];
          default: next_rdata = 16'h0000;
        endcase
      end
    end else if (addr[12:0] == `TCM_CTRL_OFS) begin
      next_rdata = ctrl_reg;
    end
  end
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= `TCM_CTRL_RESET;
      rdata <= 16'h0000;
      rvalid <= 1'b0;
      addr_drop <= 1'b0;
    end else begin
      rvalid <= acc && rd;
      addr_drop <= acc && mem_space && !a_ok;
      if (acc && rd) begin
        rdata <= next_rdata;
      end
      if (acc && wr && !mem_space && addr[12:0] == `TCM_CTRL_OFS) begin
        ctrl_reg <= wdata;
      end
    end
  end
  assign conn_low = cml_mem[o_idx];
  assign conn_high = cmh_mem[o_idx];
  // connection word decoded for the output side, registered per lookup
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      src_stream <= 5'h00;
      src_chan <= 8'h00;
      src_variable <= 1'b0;
      sw_normal <= 1'b0;
      law_convert_enable <= 1'b0;
      law_word <= 16'h0000;
      per_channel_ctrl <= 2'h0;
      msg_data <= 8'h00;
      out_tristate <= 1'b1;
      out_message <= 1'b0;
      out_ber <= 1'b0;
    end else begin
      sw_normal <= !conn_low[`TCM_CML_CMM];
      src_stream <= conn_low[`TCM_CML_SSA_HI:`TCM_CML_SSA_LO];
      src_chan <= conn_low[`TCM_CML_SCA_HI:`TCM_CML_SCA_LO];
      // variable source needs enable in ctrl; host orders the writes
      src_variable <= conn_low[`TCM_CML_VC] && ctrl_reg[`TCM_CTRL_VARIABLE_DELAY_ENABLE_BIT];
      law_convert_enable <= conn_low[`TCM_CML_LAW_CONVERT_ENABLE];
      law_word <= conn_low[`TCM_CML_LAW_CONVERT_ENABLE] ? conn_high : 16'h0000;
      per_channel_ctrl <= conn_low[`TCM_CML_PCC_HI:`TCM_CML_PCC_LO];
      msg_data <= conn_low[`TCM_CML_MSG_HI:`TCM_CML_MSG_LO];
      out_tristate <= 1'b0;
      out_message <= 1'b0;
      out_ber <= 1'b0;
      if (conn_low[`TCM_CML_CMM]) begin
        case (conn_low[`TCM_CML_PCC_HI:`TCM_CML_PCC_LO])
          `TCM_PCC_TRI: out_tristate <= 1'b1;
          `TCM_PCC_MSG: out_message <= 1'b1;
          `TCM_PCC_BER: out_ber <= 1'b1;
          default: out_tristate <= 1'b1;
        endcase
      end
    end
  end
endmodule // tcm_switch_map

//--- verification/tcm_switch_map_properties.sv
`timescale 1ns/1ps
module tcm_props (
  input wire clk_sys, input wire rst_b, input wire cs_b, input wire wr, input wire rd, input wire [13:0] addr,
  input wire [15:0] ctrl_reg, input wire rvalid, input wire sw_normal, input wire src_variable,
  input wire law_convert_enable, input wire [15:0] law_word, input wire [1:0] per_channel_ctrl,
  input wire out_message, input wire out_ber, input wire out_tristate, input wire addr_drop
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_ans; rvalid == $past(!cs_b && rd); endproperty
  a_ans: assert property (p_ans) else $error("read answer");
  property p_regsp; addr_drop |-> $past(!cs_b && addr[13]); endproperty
  a_regsp: assert property (p_regsp) else $error("drop in reg space");
  property p_ctrl; !cs_b && wr && addr[13] |=> $stable(ctrl_reg); endproperty
  a_ctrl: assert property (p_ctrl) else $error("memory write hit ctrl");
  property p_var; src_variable |-> ctrl_reg[2] || $past(ctrl_reg[2]); endproperty
  a_var: assert property (p_var) else $error("variable without enable");
  property p_norm; sw_normal |-> !(out_message || out_ber || out_tristate); endproperty
  a_norm: assert property (p_norm) else $error("special in normal");
  property p_msg; !sw_normal && per_channel_ctrl == 2'h1 |-> out_message && !out_ber; endproperty
  a_msg: assert property (p_msg) else $error("message decode");
  property p_ber; !sw_normal && per_channel_ctrl == 2'h2 |-> out_ber && !out_message; endproperty
  a_ber: assert property (p_ber) else $error("ber decode");
  property p_law; !law_convert_enable |-> law_word == 16'h0000; endproperty
  a_law: assert property (p_law) else $error("law word leaks");
endmodule // tcm_props
bind tcm_switch_map tcm_props u_props (.*);

//--- verification/tcm_host.sv
`timescale 1ns/1ps
module tcm_host (
  input wire clk_sys, output reg cs_b, output reg wr, output reg rd, output reg [13:0] addr,
  output reg [15:0] wdata, input wire [15:0] rdata, input wire rvalid, input wire addr_drop
);
  initial begin
    cs_b = 1'b1; wr = 1'b0; rd = 1'b0; addr = 14'h0000; wdata = 16'h0000;
  end
  // released bus shows inverse, not a stale value
  task acc(input is_rd, input [13:0] a, input [15:0] d, output [15:0] q, output v, output dr);
    @(posedge clk_sys);
    cs_b <= 1'b0; wr <= !is_rd; rd <= is_rd; addr <= a; wdata <= d;
    @(posedge clk_sys);
    cs_b <= 1'b1; wr <= 1'b0; rd <= 1'b0; addr <= ~a; wdata <= ~d;
    // rvalid and addr_drop stand one cycle only, so look just after the taking edge
    #1 q = rdata; v = rvalid; dr = addr_drop;
  endtask
endmodule // tcm_host

//--- verification/tcm_switch_map_test.sv
`timescale 1ns/1ps
module tcm_switch_map_test;
  reg clk_sys = 1'b0;
  reg rst_b = 1'b0;
  reg [63:0] stream_rate = 64'h0000_0000_0000_00E4;
  reg [4:0] out_stream = 5'h00;
  reg [7:0] out_chan = 8'h00;
  wire cs_b, wr, rd, rvalid, src_variable, sw_normal, law_convert_enable, out_tristate, out_message, out_ber, addr_drop;
  wire [13:0] addr;
  wire [15:0] wdata, rdata, ctrl_reg, law_word;
  wire [4:0] src_stream;
  wire [7:0] src_chan, msg_data;
  wire [1:0] per_channel_ctrl;
  reg [15:0] q, w;
  reg [7:0] c;
  reg v, dr;
  integer mismatches = 0, n_compared = 0, r;
  initial forever #5 clk_sys = ~clk_sys;
  tcm_switch_map dut (.*);
  tcm_host host (.*);
  task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("FAIL %0s exp %h got %h", nm, e, g);
    end
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task look(input [4:0] s, input [7:0] k);
    @(posedge clk_sys);
    out_stream <= s; out_chan <= k;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  initial begin
    #200000 mismatches = mismatches + 1;
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    chk("tri", 1, out_tristate);
    rst_b <= 1'b1;
    host.acc(0, 14'h0000, 16'h0006, q, v, dr);
    host.acc(0, 14'h2000, 16'h1234, q, v, dr);
    host.acc(0, 14'h0000, 16'h0005, q, v, dr);
    host.acc(1, 14'h0000, 0, q, v, dr);
    chk("ctrl", 16'h0005, q);
    chk("rvalid", 1, v);
    host.acc(1, 14'h0001, 0, q, v, dr);
    chk("unmapped", 0, q);
    $display("test regs done");
    for (r = 0; r < 4; r = r + 1) begin
      c = (32 << r) - 1;
      w = {2'b01, r[4:0], c, 1'b0};
      host.acc(0, {1'b1, r[4:0], c}, w, q, v, dr);
      host.acc(1, {1'b1, r[4:0], c}, 0, q, v, dr);
      chk("cml", w, q);
      chk("drop", 0, dr);
      if (r < 3) begin
        host.acc(1, {1'b1, r[4:0], c + 8'h01}, 0, q, v, dr);
        chk("over", 1, dr);
      end
      look(r[4:0], c);
      chk("stream", r[4:0], src_stream);
      chk("chan", c, src_chan);
      chk("var", 1, src_variable);
      chk("normal", 1, sw_normal);
      chk("law", 0, law_word);
    end
    $display("test rates done");
    for (r = 0; r < 4; r = r + 1) begin
      w = {5'h10, 8'hA5, r[1:0], 1'b1};
      host.acc(0, 14'h2000, w, q, v, dr);
      look(5'h00, 8'h00);
      chk("msg", r == 1, out_message);
      chk("ber", r == 2, out_ber);
      chk("tri", r == 0 || r == 3, out_tristate);
      chk("msgdata", 8'hA5, msg_data);
      chk("pcc", r[1:0], per_channel_ctrl);
      chk("lawen", 1, law_convert_enable);
    end
    host.acc(1, 14'h2000, 0, q, v, dr);
    chk("cml", w, q);
    chk("law", 16'h1234, law_word);
    $display("test modes done");
    wrap_up;
  end
endmodule // tcm_switch_map_test
